/* File: src/asr_pkg.sv */
// Package for the host-side controller of a 2K x 8 asynchronous static memory.
// Assumes a 100 MHz mclk; all pin timing is expressed in whole mclk cycles.
package asr_pkg;
	localparam int ADDR_W = 11;
	localparam int DATA_W = 8;
	localparam int CLK_PERIOD_NS = 10;
	// Pin timing figures in ns (slowest speed grade)
	localparam int T_RC_NS = 35;
	localparam int T_AA_NS = 35;
	localparam int T_WP_NS = 25;
	localparam int T_AS_NS = 0;
	localparam int T_DH_NS = 0;
	localparam int T_HZ_NS = 8;
	localparam int T_OH_NS = 3;
	// Least times round up, never below one cycle
	localparam int RD_CYC = ((T_AA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) < 1 ? 1 :
		((T_AA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam int WP_CYC = ((T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) < 1 ? 1 :
		((T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam int AS_CYC = ((T_AS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) < 1 ? 1 :
		((T_AS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam int DH_CYC = ((T_DH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) < 1 ? 1 :
		((T_DH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam int HZ_CYC = ((T_HZ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) < 1 ? 1 :
		((T_HZ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam int CNT_W = 3;
	localparam logic [ADDR_W-1:0] ADDR_RST = 11'h000;
	localparam logic [DATA_W-1:0] DATA_RST = 8'h00;

	typedef enum logic [2:0] {
		ASR_IDLE = 3'b000,
		ASR_SETUP = 3'b001,
		ASR_STROBE = 3'b011,
		ASR_HOLD = 3'b010,
		ASR_TURN = 3'b110
	} asr_state_t;

	typedef struct packed {
		logic wr;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} asr_req_t;

	typedef struct packed {
		logic sel_n;
		logic oe_n;
		logic we_n;
		logic [ADDR_W-1:0] addr;
	} asr_pins_t;
endpackage

/* File: src/asr_cycle_timer.sv */
// Down-counter that times each phase of a memory cycle.
// Assumes a load request and count value from the same mclk domain.
`timescale 1ns/1ps
module asr_cycle_timer (
	mclk,
	srst,
	load,
	load_val,
	done
);
	import asr_pkg::*;
	input wire logic mclk;
	input wire logic srst;
	input wire logic load;
	input wire logic [asr_pkg::CNT_W-1:0] load_val;
	output logic done;

	logic [CNT_W-1:0] cnt_r;

	assign done = (cnt_r == '0);

	always_ff @(posedge mclk) begin
		if (srst) begin
			cnt_r <= '0;
		end else if (load) begin
			cnt_r <= load_val;
		end else if (!done) begin
			cnt_r <= cnt_r - 3'h1;
		end
	end
endmodule

/* File: src/asr_host_ctrl.sv */
// Host-side controller driving a 2K x 8 asynchronous static memory over its pins.
// Assumes the memory sits on the shared data bus; the bus wire is resolved outside.
`timescale 1ns/1ps
// Functional notes
// - Write only while select and strobe low
// - Read while selected with strobe high
// - Strobe stays high throughout every read
// - Write window is overlap of select, strobe
// - Address valid before select asserts for read
module asr_host_ctrl (
	mclk,
	srst,
	req_valid,
	req_ready,
	req,
	rsp_valid,
	rsp_data,
	mem_pins,
	dq_in,
	dq_out,
	dq_oe
);
	import asr_pkg::*;
	input wire logic mclk;
	input wire logic srst;
	input wire logic req_valid;
	output logic req_ready;
	input wire asr_pkg::asr_req_t req;
	output logic rsp_valid;
	output logic [asr_pkg::DATA_W-1:0] rsp_data;
	output asr_pkg::asr_pins_t mem_pins;
	input wire logic [asr_pkg::DATA_W-1:0] dq_in;
	output logic [asr_pkg::DATA_W-1:0] dq_out;
	output logic dq_oe;

	asr_state_t state_r;
	asr_state_t state_nxt;
	asr_req_t cur_r;
	logic sel_n_r;
	logic oe_n_r;
	logic we_n_r;
	logic dq_oe_r;
	logic [DATA_W-1:0] dq_out_r;
	logic rsp_valid_r;
	logic [DATA_W-1:0] rsp_data_r;
	logic [DATA_W-1:0] dq_meta_r;
	logic [DATA_W-1:0] dq_sync_r;
	logic tmr_load;
	logic [CNT_W-1:0] tmr_val;
	logic tmr_done;
	logic take_req;
	logic in_idle;
	logic go_strobe;
	logic go_hold;
	logic go_turn;
	logic go_idle;

	function automatic logic [CNT_W-1:0] cyc(input int n);
		cyc = CNT_W'(n);
	endfunction

	asr_cycle_timer u_timer (
		.mclk(mclk),
		.srst(srst),
		.load(tmr_load),
		.load_val(tmr_val),
		.done(tmr_done)
	);

	assign in_idle = (state_r == ASR_IDLE);
	assign req_ready = in_idle;
	assign take_req = in_idle && req_valid;
	assign go_strobe = (state_r == ASR_SETUP) && tmr_done;
	// Read data is sampled two stages late, so the strobe phase adds the sync depth
	assign go_hold = (state_r == ASR_STROBE) && tmr_done;
	assign go_turn = (state_r == ASR_HOLD) && tmr_done;
	assign go_idle = (state_r == ASR_TURN) && tmr_done;
	assign tmr_load = take_req || go_strobe || go_hold || go_turn;
	// Each phase except the read strobe loads its length less one, since the timer reports done at zero
	assign tmr_val = take_req ? cyc(AS_CYC - 1) :
		go_strobe ? (cur_r.wr ? cyc(WP_CYC - 1) : cyc(RD_CYC + 1)) :
		go_hold ? cyc(DH_CYC - 1) : cyc(HZ_CYC - 1);

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ASR_IDLE: begin
				if (take_req) begin
					state_nxt = ASR_SETUP;
				end
			end
			ASR_SETUP: begin
				if (go_strobe) begin
					state_nxt = ASR_STROBE;
				end
			end
			ASR_STROBE: begin
				if (go_hold) begin
					state_nxt = ASR_HOLD;
				end
			end
			ASR_HOLD: begin
				if (go_turn) begin
					state_nxt = ASR_TURN;
				end
			end
			ASR_TURN: begin
				if (go_idle) begin
					state_nxt = ASR_IDLE;
				end
			end
			default: begin
				state_nxt = ASR_IDLE;
			end
		endcase
	end

	// Phase register; every phase but idle leaves only when its timer has run out
	always_ff @(posedge mclk) begin
		if (srst) begin
			state_r <= ASR_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// Address and data are captured once and held for the whole cycle
	always_ff @(posedge mclk) begin
		if (srst) begin
			cur_r <= '{wr: 1'b0, addr: ADDR_RST, wdata: DATA_RST};
		end else if (take_req) begin
			cur_r <= req;
		end
	end

	// Select falls only after the address has stood for a setup phase
	always_ff @(posedge mclk) begin
		if (srst) begin
			sel_n_r <= 1'b1;
		end else if (take_req) begin
			sel_n_r <= 1'b1;
		end else if (go_strobe) begin
			sel_n_r <= 1'b0;
		end else if (go_hold) begin
			sel_n_r <= 1'b1;
		end
	end

	// Write strobe only in write cycles; reads keep it high throughout
	always_ff @(posedge mclk) begin
		if (srst) begin
			we_n_r <= 1'b1;
		end else if (go_strobe && cur_r.wr) begin
			we_n_r <= 1'b0;
		end else if (go_hold) begin
			we_n_r <= 1'b1;
		end else if (!cur_r.wr) begin
			we_n_r <= 1'b1;
		end
	end

	// Output enable only for reads, never together with the write strobe
	always_ff @(posedge mclk) begin
		if (srst) begin
			oe_n_r <= 1'b1;
		end else if (go_strobe && !cur_r.wr) begin
			oe_n_r <= 1'b0;
		end else if (go_hold || cur_r.wr) begin
			oe_n_r <= 1'b1;
		end
	end

	// Host drives the bus only while the write strobe phase and data hold last
	always_ff @(posedge mclk) begin
		if (srst) begin
			dq_oe_r <= 1'b0;
			dq_out_r <= DATA_RST;
		end else if (go_strobe && cur_r.wr) begin
			dq_oe_r <= 1'b1;
			dq_out_r <= cur_r.wdata;
		end else if (go_turn) begin
			dq_oe_r <= 1'b0;
		end
	end

	// Bus level comes from the pins, so it passes two flops before capture
	always_ff @(posedge mclk) begin
		if (srst) begin
			dq_meta_r <= DATA_RST;
			dq_sync_r <= DATA_RST;
		end else begin
			dq_meta_r <= dq_in;
			dq_sync_r <= dq_meta_r;
		end
	end

	// Sample at the end of the strobe phase, before select and enable release
	always_ff @(posedge mclk) begin
		if (srst) begin
			rsp_valid_r <= 1'b0;
			rsp_data_r <= DATA_RST;
		end else begin
			rsp_valid_r <= go_hold && !cur_r.wr;
			if (go_hold && !cur_r.wr) begin
				rsp_data_r <= dq_sync_r;
			end
		end
	end

	// Pin bundle and responses all come straight from flops
	assign rsp_valid = rsp_valid_r;
	assign rsp_data = rsp_data_r;
	assign mem_pins = '{sel_n: sel_n_r, oe_n: oe_n_r, we_n: we_n_r, addr: cur_r.addr};
	assign dq_out = dq_out_r;
	assign dq_oe = dq_oe_r;
endmodule

/* File: test/asr_mem_model.sv */
// Behavioural 2K x 8 static memory standing on the controller's pins.
// Assumes registered control pins from the host; also resolves the shared data bus.
`timescale 1ns/1ps
module asr_mem_model (
	pins,
	dq_out,
	dq_oe,
	dq_bus
);
	import asr_pkg::*;
	input wire asr_pkg::asr_pins_t pins;
	input wire logic [7:0] dq_out;
	input wire logic dq_oe;
	output logic [7:0] dq_bus;
	logic [7:0] mem [2048];
	logic [7:0] last = 8'h00;
	logic [7:0] wd;
	logic [10:0] wa;
	wire wr_on = !pins.sel_n && !pins.we_n;
	wire rd_on = !pins.sel_n && !pins.oe_n && pins.we_n;
	always @* if (wr_on) begin
		wa = pins.addr;
		wd = dq_bus;
	end
	// Word lands when the overlap of select and strobe ends
	always @(negedge wr_on) mem[wa] = wd;
	always @* if (dq_oe || rd_on) last = dq_bus;
	// Released bus shows the inverse of its last level, never a stale copy
	assign dq_bus = dq_oe ? dq_out : rd_on ? mem[pins.addr] : ~last;
endmodule

/* File: test/asr_host_ctrl_assertions.sv */
// Checker for the host-side static memory controller.
// Assumes it is bound to asr_host_ctrl and sees only its ports.
`timescale 1ns/1ps
module asr_host_ctrl_chk (
	mclk,
	srst,
	req_valid,
	req_ready,
	req,
	rsp_valid,
	mem_pins,
	dq_out,
	dq_oe
);
	import asr_pkg::*;
	input wire logic mclk;
	input wire logic srst;
	input wire logic req_valid;
	input wire logic req_ready;
	input wire asr_pkg::asr_req_t req;
	input wire logic rsp_valid;
	input wire asr_pkg::asr_pins_t mem_pins;
	input wire logic [7:0] dq_out;
	input wire logic dq_oe;
	wire take = req_valid && req_ready;
	default clocking @(posedge mclk); endclocking
	default disable iff (srst);
	AST_IDLE_PINS: assert property (req_ready |-> mem_pins.sel_n && mem_pins.oe_n && mem_pins.we_n && !dq_oe)
		else $error("pins not idle while ready");
	AST_WR_DRIVE: assert property (!mem_pins.we_n |-> !mem_pins.sel_n && dq_oe && mem_pins.oe_n)
		else $error("strobe low without select and data");
	AST_NO_CLASH: assert property (!mem_pins.oe_n |-> !dq_oe && mem_pins.we_n)
		else $error("output enable overlaps host drive or strobe");
	AST_RD_WALK: assert property (take && !req.wr |=> mem_pins.sel_n ##1
		(!mem_pins.sel_n && !mem_pins.oe_n && mem_pins.we_n)[*6] ##1 (mem_pins.oe_n && mem_pins.sel_n && rsp_valid))
		else $error("read cycle shape wrong");
	AST_WR_WALK: assert property (take && req.wr |=> !dq_oe ##1 (!mem_pins.sel_n && !mem_pins.we_n && dq_oe)[*3]
		##1 (mem_pins.we_n && mem_pins.sel_n && dq_oe) ##1 !dq_oe ##1 req_ready)
		else $error("write cycle shape wrong");
	AST_ADDR_STABLE: assert property (!mem_pins.sel_n |-> $stable(mem_pins.addr))
		else $error("address moved while selected");
	AST_RD_ADDR: assert property (take && !req.wr |=> mem_pins.addr == $past(req.addr))
		else $error("read address not set before select");
	AST_WR_DATA: assert property (take && req.wr |=> ##1 mem_pins.addr == $past(req.addr, 2) && dq_out == $past(req.wdata, 2))
		else $error("write address or data wrong");
	AST_RSP_ONE: assert property (rsp_valid |=> !rsp_valid ##1 req_ready)
		else $error("response not a single pulse before ready");
endmodule
bind asr_host_ctrl asr_host_ctrl_chk u_chk (.mclk(mclk), .srst(srst), .req_valid(req_valid), .req_ready(req_ready),
	.req(req), .rsp_valid(rsp_valid), .mem_pins(mem_pins), .dq_out(dq_out), .dq_oe(dq_oe));

/* File: test/tb_async_static_ram_2k_by_8.sv */
// Testbench for the host-side static memory controller.
// Assumes the memory model and the bound checker are compiled alongside.
`timescale 1ns/1ps
module tb_async_static_ram_2k_by_8;
	import asr_pkg::*;
	logic mclk = 0, srst = 1, req_valid = 0, req_ready, rsp_valid, dq_oe;
	asr_req_t req = '0;
	logic [7:0] rsp_data, dq_in, dq_out;
	asr_pins_t mem_pins;
	int errors = 0, cmp_count = 0, cyc = 0;
	int exp_mem [int];
	asr_host_ctrl uut (.mclk(mclk), .srst(srst), .req_valid(req_valid), .req_ready(req_ready), .req(req),
		.rsp_valid(rsp_valid), .rsp_data(rsp_data), .mem_pins(mem_pins), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe));
	asr_mem_model u_mem (.pins(mem_pins), .dq_out(dq_out), .dq_oe(dq_oe), .dq_bus(dq_in));
	initial forever #5 mclk = ~mclk;
	task automatic final_report();
		$display("counts: %0d compares, %0d mismatches", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic chk_byte(string what, logic [7:0] exp, logic [7:0] got);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Request held until the edge that samples ready high
	task automatic access(bit wr, logic [10:0] a, logic [7:0] d);
		@(negedge mclk);
		req_valid = 1;
		req = '{wr, a, d};
		while (req_ready !== 1'b1) @(negedge mclk);
		@(posedge mclk);
		@(negedge mclk);
		req_valid = 0;
		if (wr) exp_mem[a] = d;
		else begin
			while (rsp_valid !== 1'b1) @(negedge mclk);
			chk_byte("read word", exp_mem[a][7:0], rsp_data);
		end
	endtask
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 3000) begin
			errors++;
			final_report();
		end
	end
	initial begin
		logic [10:0] q [$];
		void'($urandom(32'ha4fd));
		repeat (2) @(posedge mclk);
		@(negedge mclk) srst = 0;
		access(1, 11'h000, 8'ha5);
		access(1, 11'h7ff, 8'h5a);
		access(0, 11'h7ff, 8'hff);
		access(0, 11'h000, 8'h00);
		$display("test edges done");
		for (int i = 0; i < 16; i++) begin
			q.push_back(11'($urandom));
			access(1, q[i], 8'($urandom));
			access(0, q[i], 8'($urandom));
		end
		access(1, q[0], 8'h3c);
		foreach (q[i]) access(0, q[i], 8'($urandom));
		$display("test random done");
		final_report();
	end
endmodule
